// ===== include/relay_out_pkg.sv
// Package with constants and carrier types of the latched relay driver block
package relay_out_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int unsigned NUM_CHAN   = 32;
  localparam int unsigned CHAN_AW    = 5;
  localparam int unsigned MOD_AW     = 8;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS    = 10000;
  // Host silence tolerated before the outputs are dropped
  localparam int unsigned WDOG_TIME_US     = 1000;
  localparam int unsigned WDOG_CYCLES      = (WDOG_TIME_US * 1000000) / CLK_PERIOD_PS;
  // Driver and latch must agree within this time, else a fault
  localparam int unsigned MISMATCH_TIME_NS = 1000;
  localparam int unsigned MISMATCH_CYCLES  =
    (MISMATCH_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned MISMATCH_CW      = 8;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [NUM_CHAN-1:0] LATCH_RST  = 32'h0000_0000;
  localparam logic [NUM_CHAN-1:0] DRV_LVL    = 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------------
  // One host transfer, valid for one cycle while req is high
  typedef struct packed {
    logic              req;
    logic              wr;
    logic [MOD_AW-1:0] mod_addr;
    logic [CHAN_AW-1:0] chan;
    logic              state;
  } host_req_t;

  // Answer to an accepted transfer, one cycle long
  typedef struct packed {
    logic ack;
    logic rd;
    logic state;
  } host_rsp_t;

  // Health summary
  typedef enum logic [1:0] {
    LINK_RUN  = 2'b00,
    LINK_LOST = 2'b01
  } link_state_t;

endpackage : relay_out_pkg

// ===== rtl/pin_sync.sv
// Two-flop synchroniser for the driver read-back pins
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
  // Clock and control
  input  wire logic                             i_ref_clk,
  input  wire logic                             i_reset,
  input  wire logic                             i_ce,
  // Asynchronous pins in, synchronous copy out
  input  wire logic [relay_out_pkg::NUM_CHAN-1:0] i_pin,
  output logic      [relay_out_pkg::NUM_CHAN-1:0] o_sync
);

  logic [relay_out_pkg::NUM_CHAN-1:0] meta_r;
  logic [relay_out_pkg::NUM_CHAN-1:0] meta_nxt;
  logic [relay_out_pkg::NUM_CHAN-1:0] sync_r;
  logic [relay_out_pkg::NUM_CHAN-1:0] sync_nxt;

  // First stage feeds only the second; pins idle high when not pulled
  always_comb begin
    meta_nxt = meta_r;
    sync_nxt = sync_r;
    if (i_ce) begin
      meta_nxt = i_pin;
      sync_nxt = meta_r;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      meta_r <= ~relay_out_pkg::DRV_LVL;
      sync_r <= ~relay_out_pkg::DRV_LVL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign o_sync = sync_r;

endmodule : pin_sync

`default_nettype wire

// ===== rtl/relay_driver_outputs.sv
// Latched 32-channel open-drain relay driver with read-back and watchdog
`timescale 1ns/10ps
`default_nettype none

module relay_driver_outputs #(
  parameter int unsigned WDOG_CYCLES = relay_out_pkg::WDOG_CYCLES
) (
  // Clock, reset, enable
  input  wire logic                               i_ref_clk,
  input  wire logic                               i_reset,
  input  wire logic                               i_ce,
  // Slot address of this module, quasi-static
  input  wire logic [relay_out_pkg::MOD_AW-1:0]   i_slot_addr,
  // Host transfer and answer
  input  wire relay_out_pkg::host_req_t           i_host_req,
  output relay_out_pkg::host_rsp_t                o_host_rsp,
  // Open-drain channel pins
  input  wire logic [relay_out_pkg::NUM_CHAN-1:0] i_drv_pin,
  output logic      [relay_out_pkg::NUM_CHAN-1:0] o_drv_o,
  output logic      [relay_out_pkg::NUM_CHAN-1:0] o_drv_oe_n,
  // Relay board power and health
  output logic                                    o_relay_pwr_en,
  output logic                                    o_comm_lost,
  output logic                                    o_fault
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // One-hot mask for a channel number
  function automatic logic [relay_out_pkg::NUM_CHAN-1:0] chan_mask(
    input logic [relay_out_pkg::CHAN_AW-1:0] chan
  );
    logic [relay_out_pkg::NUM_CHAN-1:0] m;
    m = '0;
    m[chan] = 1'b1;
    return m;
  endfunction : chan_mask

  // Pick one channel's bit out of a vector
  function automatic logic chan_bit(
    input logic [relay_out_pkg::NUM_CHAN-1:0] vec,
    input logic [relay_out_pkg::CHAN_AW-1:0]  chan
  );
    return |(vec & chan_mask(chan));
  endfunction : chan_bit

  // ----------------------------------------------------------------------
  // Read-back synchroniser
  // ----------------------------------------------------------------------
  logic [relay_out_pkg::NUM_CHAN-1:0] pin_sync_lvl;
  logic [relay_out_pkg::NUM_CHAN-1:0] drv_on;

  pin_sync u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_ce      (i_ce),
    .i_pin     (i_drv_pin),
    .o_sync    (pin_sync_lvl)
  );

  // A channel whose pin is pulled low is a driver that conducts
  assign drv_on = ~pin_sync_lvl;

  // ----------------------------------------------------------------------
  // Host access decode
  // ----------------------------------------------------------------------
  logic hit;
  logic hit_wr;
  logic hit_rd;

  // Only transfers naming this slot count; others are ignored silently
  assign hit    = i_host_req.req && (i_host_req.mod_addr == i_slot_addr);
  assign hit_wr = hit && i_host_req.wr;
  assign hit_rd = hit && !i_host_req.wr;

  // ----------------------------------------------------------------------
  // Watchdog and link state
  // ----------------------------------------------------------------------
  relay_out_pkg::link_state_t link_r;
  relay_out_pkg::link_state_t link_nxt;
  logic [31:0]                wdog_r;
  logic [31:0]                wdog_nxt;
  logic                       lost_r;
  logic                       lost_nxt;

  // Any valid access restarts the count and revives a lost link
  always_comb begin
    link_nxt = link_r;
    wdog_nxt = wdog_r;
    lost_nxt = lost_r;
    if (i_ce) begin
      case (link_r)
        relay_out_pkg::LINK_RUN: begin
          if (hit) begin
            wdog_nxt = '0;
          end else if (wdog_r >= 32'(WDOG_CYCLES - 1)) begin
            link_nxt = relay_out_pkg::LINK_LOST;
            wdog_nxt = '0;
          end else begin
            wdog_nxt = wdog_r + 32'h0000_0001;
          end
        end
        relay_out_pkg::LINK_LOST: begin
          if (hit) begin
            link_nxt = relay_out_pkg::LINK_RUN;
            wdog_nxt = '0;
          end
        end
        default: begin
          link_nxt = relay_out_pkg::LINK_LOST;
          wdog_nxt = '0;
        end
      endcase
      // Own flop for the lost flag, so the pin never sees decode glitches
      lost_nxt = (link_nxt == relay_out_pkg::LINK_LOST);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      link_r <= relay_out_pkg::LINK_RUN;
      wdog_r <= '0;
      lost_r <= 1'b0;
    end else begin
      link_r <= link_nxt;
      wdog_r <= wdog_nxt;
      lost_r <= lost_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Channel latches and open-drain drivers
  // ----------------------------------------------------------------------
  // The enable register is the latch itself, stored inverted: a low enable
  // pulls the coil line to the driven low level, energizing the relay.
  logic [relay_out_pkg::NUM_CHAN-1:0] oe_n_r;
  logic [relay_out_pkg::NUM_CHAN-1:0] oe_n_nxt;
  logic [relay_out_pkg::NUM_CHAN-1:0] latch;
  logic [relay_out_pkg::NUM_CHAN-1:0] drv_o_r;
  logic [relay_out_pkg::NUM_CHAN-1:0] drv_o_nxt;

  assign latch = ~oe_n_r;

  // A write in the expiry cycle restarts the watchdog and is taken, and a write to a lost
  // link revives it and is latched at once; channels are forced off only in cycles without an access
  always_comb begin
    oe_n_nxt  = oe_n_r;
    drv_o_nxt = relay_out_pkg::DRV_LVL;
    if (i_ce) begin
      if (link_nxt == relay_out_pkg::LINK_LOST) begin
        oe_n_nxt = ~relay_out_pkg::LATCH_RST;
      end else if (hit_wr) begin
        // Only the addressed channel changes, the rest hold
        if (i_host_req.state) begin
          oe_n_nxt = oe_n_r & ~chan_mask(i_host_req.chan);
        end else begin
          oe_n_nxt = oe_n_r | chan_mask(i_host_req.chan);
        end
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      oe_n_r  <= ~relay_out_pkg::LATCH_RST;
      drv_o_r <= relay_out_pkg::DRV_LVL;
    end else begin
      oe_n_r  <= oe_n_nxt;
      drv_o_r <= drv_o_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Driver fault detection
  // ----------------------------------------------------------------------
  // A mismatch shorter than the filter is the normal pin and sync lag
  logic                                  mismatch;
  logic [relay_out_pkg::MISMATCH_CW-1:0] mis_cnt_r;
  logic [relay_out_pkg::MISMATCH_CW-1:0] mis_cnt_nxt;
  logic                                  fault_r;
  logic                                  fault_nxt;

  assign mismatch = |(latch ^ drv_on);

  // Fault is sticky until reset; only a restart clears a burnt driver
  always_comb begin
    mis_cnt_nxt = mis_cnt_r;
    fault_nxt   = fault_r;
    if (i_ce) begin
      if (!mismatch) begin
        mis_cnt_nxt = '0;
      end else if (mis_cnt_r >=
                   relay_out_pkg::MISMATCH_CW'(relay_out_pkg::MISMATCH_CYCLES - 1)) begin
        fault_nxt = 1'b1;
      end else begin
        mis_cnt_nxt = mis_cnt_r + relay_out_pkg::MISMATCH_CW'(1);
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      mis_cnt_r <= '0;
      fault_r   <= 1'b0;
    end else begin
      mis_cnt_r <= mis_cnt_nxt;
      fault_r   <= fault_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Relay board power
  // ----------------------------------------------------------------------
  logic pwr_r;
  logic pwr_nxt;

  // Power returns on its own once the link revives and no fault stands
  always_comb begin
    pwr_nxt = pwr_r;
    if (i_ce) begin
      pwr_nxt = (link_nxt == relay_out_pkg::LINK_RUN) && !fault_nxt;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      pwr_r <= 1'b0;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Host answer
  // ----------------------------------------------------------------------
  relay_out_pkg::host_rsp_t rsp_r;
  relay_out_pkg::host_rsp_t rsp_nxt;

  // One-cycle answer the edge after an accepted transfer; a read returns
  // the driver as seen on the pin so the host can compare it
  always_comb begin
    rsp_nxt = rsp_r;
    if (i_ce) begin
      rsp_nxt.ack   = hit;
      rsp_nxt.rd    = hit_rd;
      rsp_nxt.state = hit_rd && chan_bit(drv_on, i_host_req.chan);
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      rsp_r <= '0;
    end else begin
      rsp_r <= rsp_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign o_host_rsp     = rsp_r;
  assign o_drv_o        = drv_o_r;
  assign o_drv_oe_n     = oe_n_r;
  assign o_relay_pwr_en = pwr_r;
  assign o_comm_lost    = lost_r;
  assign o_fault        = fault_r;

endmodule : relay_driver_outputs

`default_nettype wire

// ===== tb/relay_board_model.sv
// Relay board model: pulls each driver line up unless its driver conducts
`timescale 1ns/10ps
`default_nettype none

module relay_board_model (
  // Driver side of the cable
  input  wire logic [relay_out_pkg::NUM_CHAN-1:0] i_oe_n,
  input  wire logic [relay_out_pkg::NUM_CHAN-1:0] i_drv_o,
  // Drivers that the bench breaks on purpose
  input  wire logic [relay_out_pkg::NUM_CHAN-1:0] i_broken,
  // Line level and coil state
  output logic      [relay_out_pkg::NUM_CHAN-1:0] o_pin,
  output logic      [relay_out_pkg::NUM_CHAN-1:0] o_coil_on
);
  // Pull-up wins wherever a driver is off or broken, so no stale level is seen
  assign o_pin     = ~(~i_oe_n & ~i_drv_o & ~i_broken);
  assign o_coil_on = ~o_pin;
endmodule : relay_board_model
`default_nettype wire

// ===== tb/relay_out_chk.sv
// Checker of host answers, latch outputs, watchdog and fault behaviour
`timescale 1ns/10ps
`default_nettype none

module relay_out_chk #(
  parameter int unsigned WDOG_CYCLES = 200
) (
  // Clock and control
  input wire logic                               i_ref_clk,
  input wire logic                               i_reset,
  input wire logic                               i_ce,
  // Host side
  input wire logic [relay_out_pkg::MOD_AW-1:0]   i_slot_addr,
  input wire relay_out_pkg::host_req_t           i_host_req,
  input wire relay_out_pkg::host_rsp_t           o_host_rsp,
  // Channel and health side
  input wire logic [relay_out_pkg::NUM_CHAN-1:0] i_drv_pin,
  input wire logic [relay_out_pkg::NUM_CHAN-1:0] o_drv_o,
  input wire logic [relay_out_pkg::NUM_CHAN-1:0] o_drv_oe_n,
  input wire logic                               o_relay_pwr_en,
  input wire logic                               o_comm_lost,
  input wire logic                               o_fault
);
  logic                               hit;
  logic [31:0]                        idle_r;
  logic [31:0]                        idle_nxt;
  logic [relay_out_pkg::NUM_CHAN-1:0] wmask_r;
  logic [relay_out_pkg::NUM_CHAN-1:0] wmask_nxt;

  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  assign hit = i_ce && i_host_req.req && (i_host_req.mod_addr == i_slot_addr);
  // Idle count saturates so that it never wraps back under the limit
  always_comb begin
    idle_nxt  = idle_r;
    wmask_nxt = 32'h0000_0000;
    if (hit) idle_nxt = 32'h0;
    else if (i_ce && idle_r < WDOG_CYCLES + 2) idle_nxt = idle_r + 32'h1;
    if (hit && i_host_req.wr) wmask_nxt = 32'h0000_0001 << i_host_req.chan;
  end
  always_ff @(posedge i_ref_clk) begin
    idle_r  <= i_reset ? 32'h0 : idle_nxt;
    wmask_r <= i_reset ? 32'h0000_0000 : wmask_nxt;
  end

  sequence s_take_wr;
    hit && i_host_req.wr;
  endsequence
  sequence s_pin_quiet;
    (i_ce && $stable(i_drv_pin)) [*3];
  endsequence

  a_ack_after_take: assert property (hit |=> o_host_rsp.ack)
    else $error("no answer after a taken transfer");
  a_no_stray_ack: assert property (i_ce && !hit |=> !o_host_rsp.ack)
    else $error("answer without a taken transfer");
  a_latch_capture: assert property (s_take_wr |=> o_comm_lost ||
    (o_drv_oe_n[$past(i_host_req.chan)] == !$past(i_host_req.state)))
    else $error("addressed channel did not take the written state");
  a_others_hold: assert property (!o_comm_lost |->
    ((o_drv_oe_n ^ $past(o_drv_oe_n)) & ~wmask_r) == 32'h0000_0000)
    else $error("a channel changed without being written");
  a_read_state: assert property (s_pin_quiet ##0 (hit && !i_host_req.wr) |=>
    o_host_rsp.rd && (o_host_rsp.state == !$past(i_drv_pin[i_host_req.chan])))
    else $error("read answer does not show the driver state");
  a_lost_all_off: assert property (o_comm_lost |-> (&o_drv_oe_n) && !o_relay_pwr_en)
    else $error("outputs or relay power still on with the host lost");
  a_fault_kills_pwr: assert property (o_fault |-> !o_relay_pwr_en)
    else $error("relay power on during a fault");
  a_fault_sticky: assert property (o_fault |=> o_fault)
    else $error("fault cleared without reset");
  a_drain_level: assert property (o_drv_o == 32'h0000_0000)
    else $error("open-drain level not low");
  a_wdog_expiry: assert property (idle_r > WDOG_CYCLES |-> o_comm_lost)
    else $error("watchdog did not expire in time");
  a_wdog_early: assert property (o_comm_lost |-> idle_r + 32'h1 >= WDOG_CYCLES)
    else $error("watchdog expired early or missed a host access");
endmodule : relay_out_chk

bind relay_driver_outputs relay_out_chk #(.WDOG_CYCLES(WDOG_CYCLES)) u_chk (
  .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_ce(i_ce), .i_slot_addr(i_slot_addr),
  .i_host_req(i_host_req), .o_host_rsp(o_host_rsp), .i_drv_pin(i_drv_pin),
  .o_drv_o(o_drv_o), .o_drv_oe_n(o_drv_oe_n), .o_relay_pwr_en(o_relay_pwr_en),
  .o_comm_lost(o_comm_lost), .o_fault(o_fault)
);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the latched relay driver block
`timescale 1ns/10ps
`default_nettype none

module testbench;
  localparam int unsigned WDOG = 200;
  localparam logic [7:0]  SLOT = 8'h5A;
  typedef struct packed { logic wr; logic [4:0] chan; logic state; logic [31:0] coil; } row_t;

  logic ref_clk, reset, ce;
  relay_out_pkg::host_req_t host_req;
  relay_out_pkg::host_rsp_t host_rsp;
  logic [31:0] drv_pin, drv_o, drv_oe_n, broken, coil_on;
  logic        relay_pwr_en, comm_lost, fault;
  int          failures, checked, cycles;
  // Ordinary traffic: command beside the coil pattern it should leave
  row_t rows [8] = '{'{1'h1, 5'h00, 1'h1, 32'h0000_0001}, '{1'h1, 5'h1F, 1'h1, 32'h8000_0001},
    '{1'h0, 5'h00, 1'h0, 32'h8000_0001}, '{1'h1, 5'h00, 1'h0, 32'h8000_0000},
    '{1'h0, 5'h00, 1'h0, 32'h8000_0000}, '{1'h0, 5'h1F, 1'h0, 32'h8000_0000},
    '{1'h1, 5'h11, 1'h1, 32'h8002_0000}, '{1'h0, 5'h11, 1'h0, 32'h8002_0000}};

  relay_driver_outputs #(.WDOG_CYCLES(WDOG)) uut (
    .i_ref_clk(ref_clk), .i_reset(reset), .i_ce(ce), .i_slot_addr(SLOT),
    .i_host_req(host_req), .o_host_rsp(host_rsp), .i_drv_pin(drv_pin), .o_drv_o(drv_o),
    .o_drv_oe_n(drv_oe_n), .o_relay_pwr_en(relay_pwr_en), .o_comm_lost(comm_lost),
    .o_fault(fault));
  relay_board_model u_board (.i_oe_n(drv_oe_n), .i_drv_o(drv_o), .i_broken(broken),
    .o_pin(drv_pin), .o_coil_on(coil_on));

  initial ref_clk = 1'h0;
  always #5 ref_clk = ~ref_clk;

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // One transfer; returns just after the edge that presents the answer
  task automatic xfer(input logic wr, input logic [7:0] md, input logic [4:0] ch, input logic st);
    @(posedge ref_clk);
    host_req <= '{1'h1, wr, md, ch, st};
    @(posedge ref_clk);
    host_req <= '0;
    #1;
  endtask : xfer

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : wait_cycles

  task automatic report_and_stop;
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : report_and_stop

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  initial begin
    reset = 1'h1; ce = 1'h1; host_req = '0; broken = 32'h0; failures = 0; checked = 0; cycles = 0;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    wait_cycles(2);
    check("power", 1'h1, relay_pwr_en);
    check("oe_n", 32'hFFFF_FFFF, drv_oe_n);
    check("drain level", 32'h0000_0000, drv_o);
    check("lost", 1'h0, comm_lost);
    check("fault", 1'h0, fault);
    foreach (rows[i]) begin
      xfer(rows[i].wr, SLOT, rows[i].chan, rows[i].state);
      check("ack", 1'h1, host_rsp.ack);
      check("rd", !rows[i].wr, host_rsp.rd);
      if (!rows[i].wr) check("read back", rows[i].coil[rows[i].chan], host_rsp.state);
      wait_cycles(4);
      check("coils", rows[i].coil, coil_on);
    end
    // Foreign slot address and a frozen clock enable are both ignored
    xfer(1'h1, 8'hA5, 5'h01, 1'h1);
    check("stray ack", 1'h0, host_rsp.ack);
    @(posedge ref_clk) ce <= 1'h0;
    xfer(1'h1, SLOT, 5'h04, 1'h1);
    @(posedge ref_clk) ce <= 1'h1;
    wait_cycles(3);
    check("coils", 32'h8002_0000, coil_on);
    // Back-to-back writes on consecutive edges
    @(posedge ref_clk) host_req <= '{1'h1, 1'h1, SLOT, 5'h02, 1'h1};
    @(posedge ref_clk) host_req <= '{1'h1, 1'h1, SLOT, 5'h03, 1'h1};
    @(posedge ref_clk) host_req <= '0;
    wait_cycles(3);
    check("coils", 32'h8002_000C, coil_on);
    // Host silence: everything drops, one access brings power back, latches stay off
    wait_cycles(WDOG + 3);
    check("lost", 1'h1, comm_lost);
    check("oe_n", 32'hFFFF_FFFF, drv_oe_n);
    check("power", 1'h0, relay_pwr_en);
    xfer(1'h0, SLOT, 5'h11, 1'h0);
    check("read back", 1'h0, host_rsp.state);
    wait_cycles(2);
    check("lost", 1'h0, comm_lost);
    check("power", 1'h1, relay_pwr_en);
    // A broken driver leaves its line high: sticky fault, power off, latches still work
    @(posedge ref_clk) broken <= 32'h0000_0020;
    xfer(1'h1, SLOT, 5'h05, 1'h1);
    wait_cycles(115);
    check("fault", 1'h1, fault);
    check("power", 1'h0, relay_pwr_en);
    xfer(1'h0, SLOT, 5'h05, 1'h0);
    check("read back", 1'h0, host_rsp.state);
    xfer(1'h1, SLOT, 5'h06, 1'h1);
    wait_cycles(3);
    check("coils", 32'h0000_0040, coil_on);
    check("fault", 1'h1, fault);
    @(posedge ref_clk) reset <= 1'h1;
    repeat (4) @(posedge ref_clk);
    reset <= 1'h0;
    wait_cycles(2);
    check("fault", 1'h0, fault);
    check("coils", 32'h0000_0000, coil_on);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
